// *** scq_pkg.sv ***
/*
 * Shared constants for the state clock, qualifier and label front end.
 * Assumes one sampling clock domain; pins are synchronised inside the block.
 */
package scq_pkg;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NUM_CLK = 6;
    localparam int NUM_QUAL = 4;
    localparam int GRP_CLK = 3;
    localparam int GRP_QUAL = 2;
    localparam int POD_W = 16;
    localparam int NUM_POD = 4;
    localparam int CH_W = NUM_POD * POD_W;
    localparam int LBL_W = 32;
    localparam int LBL_MAX_CH = 32;
    localparam int NUM_LBL = 126;
    localparam int LBL_IDX_W = 7;
    localparam int NUM_SYM = 1000;
    localparam int SYM_IDX_W = 10;
    localparam int CNT_W = 7;
    localparam logic Q_AND = 1'b0;
    localparam logic Q_OR = 1'b1;
    localparam logic POL_POS = 1'b0;
    localparam logic SYM_PATTERN = 1'b0;
    localparam logic SYM_RANGE = 1'b1;
    typedef enum logic [1:0] {POD_MASTER, POD_SLAVE, POD_DEMUX} scq_pod_e;
endpackage

// *** scq_front_end.sv ***
/*
 * State-mode front end: strobe builder from clock and qualifier pins,
 * master/slave/demux pod sampling, label packing with polarity, pattern
 * compare and a shared symbol matcher.
 * Assumes pins are asynchronous to clk_sys and are slow enough that the
 * two-flop synchronisers plus an edge detector see every level change.
 */
// What this block does
// RULE1 - Up to six clock pins and four qualifier pins feed the strobe builder.
// RULE2 - Any enabled edge on any clock gives a candidate strobe.
// RULE3 - Qualifiers gate edges by AND; qualifiers combine by AND or OR.
// RULE4 - Clocks 0-2 with qualifiers a,b; clocks 3-5 with c,d; groups ORed.
// RULE5 - On master strobe all master pods are stored in one sample.
// RULE6 - Slave pods latch on slave strobe; last latched value goes with master.
// RULE7 - Demux samples one pod of a pair; slave and master fill two fields.
// RULE8 - A label holds one to thirty-two channels.
// RULE9 - More than thirty-two channels in a label is rejected with an error.
// RULE10 - Lowest assigned channel is label bit zero; highest bit is thirty-one.
// RULE11 - Channels from split fields pack into consecutive bits without gaps.
// RULE12 - Each pod gives at most sixteen channels.
// RULE13 - Up to one hundred twenty-six labels are configurable.
// RULE14 - Turning a label off keeps its channel assignment.
// RULE15 - Label polarity resets to positive.
// RULE16 - Negative polarity reads a low level as one, high as zero.
// RULE17 - Pattern compares use the polarity-adjusted value.
// RULE18 - At most one thousand symbols in total.
// RULE19 - Symbols belong to one label and compare only with that label.
// RULE20 - A symbol is one pattern or an inclusive range; overlaps allowed.
// RULE21 - Strobe is one clock cycle per qualified edge, in the sampling clock.
module scq_front_end (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [5:0] ext_clk,
    input wire logic qualifier_a,
    input wire logic qualifier_b,
    input wire logic qualifier_c,
    input wire logic qualifier_d,
    input wire logic [63:0] pod_data,
    input wire logic [11:0] mst_edge_en,
    input wire logic [3:0] mst_qual_en,
    input wire logic [3:0] mst_qual_lvl,
    input wire logic [1:0] mst_qual_mode,
    input wire logic [11:0] slv_edge_en,
    input wire logic [3:0] slv_qual_en,
    input wire logic [3:0] slv_qual_lvl,
    input wire logic [1:0] slv_qual_mode,
    input wire logic [7:0] pod_mode,
    input wire logic map_wr,
    input wire logic [6:0] map_idx,
    input wire logic [63:0] map_mask,
    input wire logic attr_wr,
    input wire logic [6:0] attr_idx,
    input wire logic attr_on,
    input wire logic attr_neg,
    input wire logic [6:0] view_idx,
    input wire logic [31:0] trig_pattern,
    input wire logic sym_wr,
    input wire logic [9:0] sym_wr_idx,
    input wire logic sym_wr_valid,
    input wire logic [6:0] sym_wr_label,
    input wire logic sym_wr_type,
    input wire logic [31:0] sym_wr_start,
    input wire logic [31:0] sym_wr_stop,
    input wire logic [9:0] sym_query_idx,
    output logic sample_valid_ff,
    output logic [63:0] sample_data_ff,
    output logic slave_strobe_ff,
    output logic map_err_ff,
    output logic [31:0] label_value_ff,
    output logic label_on_ff,
    output logic trig_match_ff,
    output logic sym_hit_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // Qualified strobe of one half; no qualifier enabled means ungated
    function automatic logic grp_strobe(input logic [2:0] rise, input logic [2:0] fall,
                                        input logic [5:0] edge_en, input logic [1:0] lvl,
                                        input logic [1:0] q_en, input logic [1:0] q_lvl,
                                        input logic mode);
        logic any_edge;
        logic [1:0] hit;
        logic qual;
        any_edge = |(rise & edge_en[2:0]) | |(fall & edge_en[5:3]); // [RULE2]
        hit = ~(lvl ^ q_lvl);
        if (q_en == 2'b00)
            qual = 1'b1;
        else if (mode == scq_pkg::Q_OR)
            qual = |(hit & q_en); // [RULE3]
        else
            qual = &(hit | ~q_en); // [RULE3]
        return any_edge & qual; // [RULE3]
    endfunction

    // Full strobe: two halves ORed together
    function automatic logic strobe_of(input logic [5:0] rise, input logic [5:0] fall,
                                       input logic [3:0] qlv, input logic [11:0] edge_en,
                                       input logic [3:0] q_en, input logic [3:0] q_lvl,
                                       input logic [1:0] mode);
        logic lo;
        logic hi;
        lo = grp_strobe(rise[2:0], fall[2:0], {edge_en[8:6], edge_en[2:0]}, qlv[1:0],
                        q_en[1:0], q_lvl[1:0], mode[0]);
        hi = grp_strobe(rise[5:3], fall[5:3], {edge_en[11:9], edge_en[5:3]}, qlv[3:2],
                        q_en[3:2], q_lvl[3:2], mode[1]);
        return lo | hi; // [RULE4]
    endfunction

    // Packs masked channels into consecutive bits, lowest channel first
    function automatic logic [31:0] pack_ch(input logic [63:0] data, input logic [63:0] mask);
        logic [31:0] val;
        logic [5:0] pos;
        val = '0;
        pos = '0;
        for (int i = 0; i < scq_pkg::CH_W; i++)
        begin
            if (mask[i] && pos < 6'(scq_pkg::LBL_W))
            begin
                val[pos[4:0]] = data[i]; // [RULE10] [RULE11]
                pos = pos + 6'h01;
            end
        end
        return val;
    endfunction

    // Channel count of a mask
    function automatic logic [6:0] count_ch(input logic [63:0] mask);
        logic [6:0] n;
        n = '0;
        for (int i = 0; i < scq_pkg::CH_W; i++)
            n = n + 7'(mask[i]);
        return n;
    endfunction

    // Polarity-adjusted label value; inversion limited to assigned bits
    function automatic logic [31:0] label_val(input logic [63:0] data, input logic [63:0] mask,
                                              input logic neg);
        logic [31:0] raw;
        logic [31:0] used;
        raw = pack_ch(data, mask);
        used = pack_ch(mask, mask);
        return neg ? (~raw & used) : raw; // [RULE16]
    endfunction

    // Two-flop synchronisers plus a third stage for edge detection
    logic [5:0] clk_s1_ff, clk_s2_ff, clk_s3_ff;
    logic [3:0] q_s1_ff, q_s2_ff;
    logic [63:0] pod_s1_ff, pod_s2_ff;
    logic [5:0] clk_rise, clk_fall;
    logic mst_strobe, slv_strobe;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clk_s1_ff <= '0;
            clk_s2_ff <= '0;
            clk_s3_ff <= '0;
            q_s1_ff <= '0;
            q_s2_ff <= '0;
            pod_s1_ff <= '0;
            pod_s2_ff <= '0;
        end
        else
        begin
            clk_s1_ff <= ext_clk; // [RULE1]
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            q_s1_ff <= {qualifier_d, qualifier_c, qualifier_b, qualifier_a}; // [RULE1]
            q_s2_ff <= q_s1_ff;
            pod_s1_ff <= pod_data;
            pod_s2_ff <= pod_s1_ff;
        end
    end

    // Edge flags last exactly one cycle per pin transition
    assign clk_rise = clk_s2_ff & ~clk_s3_ff; // [RULE21]
    assign clk_fall = ~clk_s2_ff & clk_s3_ff; // [RULE21]
    assign mst_strobe = strobe_of(clk_rise, clk_fall, q_s2_ff, mst_edge_en, mst_qual_en,
                                  mst_qual_lvl, mst_qual_mode);
    assign slv_strobe = strobe_of(clk_rise, clk_fall, q_s2_ff, slv_edge_en, slv_qual_en,
                                  slv_qual_lvl, slv_qual_mode);

    // Slave latches and stored sample
    logic [63:0] slv_lat_ff, nxt_slv_lat;
    logic [63:0] nxt_sample;
    logic nxt_valid, nxt_slv_pulse;

    always_comb
    begin
        nxt_slv_lat = slv_strobe ? pod_s2_ff : slv_lat_ff; // [RULE6]
        nxt_sample = sample_data_ff;
        nxt_valid = mst_strobe; // [RULE21]
        nxt_slv_pulse = slv_strobe;
        if (mst_strobe)
        begin
            for (int p = 0; p < scq_pkg::NUM_POD; p++)
            begin
                // Even pod of a demux pair owns both slots of the pair
                // Pair base taken as (p/2) so pod 0 never forms a negative select
                if (p % 2 == 1 && scq_pkg::scq_pod_e'(pod_mode[(p/2)*4 +: 2]) ==
                    scq_pkg::POD_DEMUX)
                    nxt_sample[p*scq_pkg::POD_W +: scq_pkg::POD_W] =
                        slv_lat_ff[(p/2)*2*scq_pkg::POD_W +: scq_pkg::POD_W]; // [RULE7]
                else if (scq_pkg::scq_pod_e'(pod_mode[p*2 +: 2]) == scq_pkg::POD_SLAVE)
                    nxt_sample[p*scq_pkg::POD_W +: scq_pkg::POD_W] =
                        slv_lat_ff[p*scq_pkg::POD_W +: scq_pkg::POD_W]; // [RULE6]
                else
                    nxt_sample[p*scq_pkg::POD_W +: scq_pkg::POD_W] =
                        pod_s2_ff[p*scq_pkg::POD_W +: scq_pkg::POD_W]; // [RULE5] [RULE7]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            slv_lat_ff <= '0;
            sample_data_ff <= '0;
            sample_valid_ff <= 1'b0;
            slave_strobe_ff <= 1'b0;
        end
        else
        begin
            slv_lat_ff <= nxt_slv_lat;
            sample_data_ff <= nxt_sample;
            sample_valid_ff <= nxt_valid;
            slave_strobe_ff <= nxt_slv_pulse;
        end
    end

    // Label table; masks are memory, attributes are reset state
    logic [63:0] lbl_mask_mem [scq_pkg::NUM_LBL]; // [RULE13]
    logic [scq_pkg::NUM_LBL-1:0] lbl_on_ff, nxt_lbl_on;
    logic [scq_pkg::NUM_LBL-1:0] lbl_neg_ff, nxt_lbl_neg;
    logic map_ok, nxt_map_err;
    logic [6:0] map_cnt;

    always_comb
    begin
        map_cnt = count_ch(map_mask);
        // Pods are 16 wide, so no pod can give more than its 16 channels
        map_ok = map_wr && map_idx < 7'(scq_pkg::NUM_LBL) && map_cnt != 7'h00 &&
                 map_cnt <= 7'(scq_pkg::LBL_MAX_CH); // [RULE8] [RULE12]
        nxt_map_err = map_wr && !map_ok; // [RULE9]
        nxt_lbl_on = lbl_on_ff;
        nxt_lbl_neg = lbl_neg_ff;
        if (attr_wr && attr_idx < 7'(scq_pkg::NUM_LBL))
        begin
            nxt_lbl_on[attr_idx] = attr_on; // [RULE14]
            nxt_lbl_neg[attr_idx] = attr_neg;
        end
    end

    // Mask memory is only written by an accepted map; off leaves it alone
    always_ff @(posedge clk_sys)
    begin
        if (map_ok)
            lbl_mask_mem[map_idx] <= map_mask; // [RULE9] [RULE14]
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lbl_on_ff <= '0;
            lbl_neg_ff <= {scq_pkg::NUM_LBL{scq_pkg::POL_POS}}; // [RULE15]
            map_err_ff <= 1'b0;
        end
        else
        begin
            lbl_on_ff <= nxt_lbl_on;
            lbl_neg_ff <= nxt_lbl_neg;
            map_err_ff <= nxt_map_err;
        end
    end

    // Symbol table, shared by all labels
    logic sym_valid_mem [scq_pkg::NUM_SYM]; // [RULE18]
    logic [6:0] sym_label_mem [scq_pkg::NUM_SYM];
    logic sym_type_mem [scq_pkg::NUM_SYM];
    logic [31:0] sym_start_mem [scq_pkg::NUM_SYM];
    logic [31:0] sym_stop_mem [scq_pkg::NUM_SYM];
    logic sym_wr_ok;

    assign sym_wr_ok = sym_wr && sym_wr_idx < 10'(scq_pkg::NUM_SYM); // [RULE18]

    // Valid bits cleared at reset so an empty table never matches
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int s = 0; s < scq_pkg::NUM_SYM; s++)
                sym_valid_mem[s] <= 1'b0;
        end
        else if (sym_wr_ok)
            sym_valid_mem[sym_wr_idx] <= sym_wr_valid;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sym_wr_ok)
        begin
            sym_label_mem[sym_wr_idx] <= sym_wr_label; // [RULE19]
            sym_type_mem[sym_wr_idx] <= sym_wr_type;
            sym_start_mem[sym_wr_idx] <= sym_wr_start;
            sym_stop_mem[sym_wr_idx] <= sym_wr_stop;
        end
    end

    // Viewed label value, pattern compare and symbol query
    logic [31:0] nxt_label_value;
    logic nxt_label_on, nxt_trig, nxt_sym_hit;
    logic [31:0] sym_val;
    logic [6:0] sym_lbl;
    logic [6:0] view_sel;

    always_comb
    begin
        view_sel = view_idx < 7'(scq_pkg::NUM_LBL) ? view_idx : 7'h00;
        nxt_label_value = label_val(sample_data_ff, lbl_mask_mem[view_sel],
                                    lbl_neg_ff[view_sel]); // [RULE16]
        nxt_label_on = view_idx < 7'(scq_pkg::NUM_LBL) && lbl_on_ff[view_sel];
        // Pattern is given in the label's logical encoding
        nxt_trig = nxt_label_on && nxt_label_value == trig_pattern; // [RULE17]
        nxt_sym_hit = 1'b0;
        sym_lbl = 7'h00;
        sym_val = '0;
        if (sym_query_idx < 10'(scq_pkg::NUM_SYM))
        begin
            sym_lbl = sym_label_mem[sym_query_idx];
            if (sym_lbl < 7'(scq_pkg::NUM_LBL))
            begin
                // Only the symbol's own label is compared
                sym_val = label_val(sample_data_ff, lbl_mask_mem[sym_lbl],
                                    lbl_neg_ff[sym_lbl]); // [RULE19] [RULE17]
                if (sym_valid_mem[sym_query_idx] && lbl_on_ff[sym_lbl])
                begin
                    if (sym_type_mem[sym_query_idx] == scq_pkg::SYM_RANGE)
                        nxt_sym_hit = sym_val >= sym_start_mem[sym_query_idx] &&
                                      sym_val <= sym_stop_mem[sym_query_idx]; // [RULE20]
                    else
                        nxt_sym_hit = sym_val == sym_start_mem[sym_query_idx]; // [RULE20]
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            label_value_ff <= '0;
            label_on_ff <= 1'b0;
            trig_match_ff <= 1'b0;
            sym_hit_ff <= 1'b0;
        end
        else
        begin
            label_value_ff <= nxt_label_value;
            label_on_ff <= nxt_label_on;
            trig_match_ff <= nxt_trig;
            sym_hit_ff <= nxt_sym_hit;
        end
    end
endmodule

// *** scq_props.sv ***
/*
 * Checker for the state front end: strobe timing, qualifier gating,
 * sample holding, map rejection and trigger gating.
 * Assumes it sees only top-level ports, bound in below.
 */
module scq_props (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [5:0] ext_clk,
    input wire logic qualifier_a,
    input wire logic qualifier_b,
    input wire logic [11:0] mst_edge_en,
    input wire logic [3:0] mst_qual_en,
    input wire logic [3:0] mst_qual_lvl,
    input wire logic [1:0] mst_qual_mode,
    input wire logic map_wr,
    input wire logic [6:0] map_idx,
    input wire logic [63:0] map_mask,
    input wire logic sample_valid_ff,
    input wire logic [63:0] sample_data_ff,
    input wire logic slave_strobe_ff,
    input wire logic map_err_ff,
    input wire logic label_on_ff,
    input wire logic trig_match_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // Lone rising edge on clock 0 with no qualifier in play
    sequence s_clk0_rise;
        $rose(ext_clk[0]) && mst_edge_en == 12'h001 && mst_qual_en == 4'h0;
    endsequence
    // Same edge, but an AND-combined low-group qualifier is wrong
    sequence s_clk0_blocked;
        $rose(ext_clk[0]) && mst_edge_en == 12'h001 && mst_qual_en == 4'hf
            && !mst_qual_mode[0]
            && (qualifier_a != mst_qual_lvl[0] || qualifier_b != mst_qual_lvl[1]);
    endsequence

    chk_edge_strobe: assert property (s_clk0_rise |-> ##[1:4] sample_valid_ff)
        else $error("edge gave no sample strobe");
    chk_qual_gate: assert property (s_clk0_blocked |-> ##1 !sample_valid_ff [*6])
        else $error("strobe despite failed qualifier");
    chk_valid_single: assert property (sample_valid_ff |=> !sample_valid_ff)
        else $error("sample strobe longer than one cycle");
    chk_slave_single: assert property (slave_strobe_ff |=> !slave_strobe_ff)
        else $error("slave strobe longer than one cycle");
    chk_data_hold: assert property (!sample_valid_ff |-> $stable(sample_data_ff))
        else $error("sample changed without strobe");
    chk_err_cause: assert property (map_err_ff |-> $past(map_wr))
        else $error("map error without a map write");
    chk_err_oversize: assert property (map_wr && $countones(map_mask) > 32
        |=> map_err_ff)
        else $error("oversize label map accepted");
    chk_map_accept: assert property (map_wr && map_idx < 7'h7e
        && map_mask != 64'h0 && $countones(map_mask) <= 32 |=> !map_err_ff)
        else $error("legal label map rejected");
    chk_err_index: assert property (map_wr && map_idx > 7'h7d |=> map_err_ff)
        else $error("map to missing label accepted");
    chk_trig_on: assert property (trig_match_ff |-> label_on_ff)
        else $error("trigger match on a label that is off");
endmodule

bind scq_front_end scq_props u_props (.clk_sys, .arst_n, .ext_clk, .qualifier_a, .qualifier_b,
    .mst_edge_en, .mst_qual_en, .mst_qual_lvl, .mst_qual_mode, .map_wr, .map_idx, .map_mask,
    .sample_valid_ff, .sample_data_ff, .slave_strobe_ff, .map_err_ff, .label_on_ff,
    .trig_match_ff);

// *** scq_target.sv ***
/*
 * Probed target model: drives clock pins, qualifier pins and pod data.
 * Assumes the bench calls its tasks; pins change 2 ns after a clock edge.
 */
module scq_target (
    input wire logic clk_sys,
    output logic [5:0] ext_clk,
    output logic [3:0] qual,
    output logic [63:0] pod_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins idle low, data always driven by the target
    initial
    begin
        ext_clk = 6'h00;
        qual = 4'h0;
        pod_data = 64'h0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // Qualifiers settle well before any edge they gate
    task automatic set_qual(input logic [3:0] q);
        qual = q;
        step(3);
    endtask
    // One clock pulse; wide enough for the synchronisers to see both edges
    task automatic strobe(input int pin, input logic [63:0] d);
        pod_data = d;
        step(3);
        ext_clk[pin] = 1'b1;
        step(4);
        ext_clk[pin] = 1'b0;
        step(4);
    endtask
endmodule

// *** scq_front_end_bench.sv ***
/*
 * Bench for the state front end: strobes, slave and demux sampling,
 * label packing, polarity, trigger compare and symbols.
 * Assumes the target model drives pins and the checker is bound in.
 */
module scq_front_end_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] ext_clk;
    logic [3:0] qual;
    logic [63:0] pod_data, sample_data_ff, s;
    logic [63:0] map_mask = 64'h0, m1 = 64'h8000_0000_0010_0030;
    logic [11:0] mst_edge_en = 12'h000, slv_edge_en = 12'h000;
    logic [3:0] mst_qual_en = 4'h0, mst_qual_lvl = 4'h0, slv_qual_en = 4'h0, slv_qual_lvl = 4'h0;
    logic [1:0] mst_qual_mode = 2'h0, slv_qual_mode = 2'h0;
    logic [7:0] pod_mode = 8'h00;
    logic map_wr = 1'b0, attr_wr = 1'b0, attr_on = 1'b0, attr_neg = 1'b0, sym_wr = 1'b0;
    logic sym_wr_valid = 1'b1, sym_wr_type = 1'b0;
    logic [6:0] map_idx = 7'h00, attr_idx = 7'h00, view_idx = 7'h00, sym_wr_label = 7'h00;
    logic [31:0] trig_pattern = 32'h0, sym_wr_start = 32'h0, sym_wr_stop = 32'h0, label_value_ff;
    logic [9:0] sym_wr_idx = 10'h000, sym_query_idx = 10'h000;
    logic sample_valid_ff, slave_strobe_ff, map_err_ff, label_on_ff, trig_match_ff, sym_hit_ff;
    int failures = 0, n_compared = 0, n_valid = 0, n_slave = 0;
    // Qualifier cases: group, OR mode, pins d c b a, strobe expected
    logic [6:0] qtab [8] = '{7'h02, 7'h07, 7'h23, 7'h20, 7'h49, 7'h58, 7'h70, 7'h79};

    scq_target tgt (.clk_sys, .ext_clk, .qual, .pod_data);
    scq_front_end dut (.clk_sys, .arst_n, .ext_clk, .qualifier_a(qual[0]), .qualifier_b(qual[1]),
        .qualifier_c(qual[2]), .qualifier_d(qual[3]), .pod_data, .mst_edge_en, .mst_qual_en,
        .mst_qual_lvl, .mst_qual_mode, .slv_edge_en, .slv_qual_en, .slv_qual_lvl, .slv_qual_mode,
        .pod_mode, .map_wr, .map_idx, .map_mask, .attr_wr, .attr_idx, .attr_on, .attr_neg,
        .view_idx, .trig_pattern, .sym_wr, .sym_wr_idx, .sym_wr_valid, .sym_wr_label, .sym_wr_type,
        .sym_wr_start, .sym_wr_stop, .sym_query_idx, .sample_valid_ff, .sample_data_ff,
        .slave_strobe_ff, .map_err_ff, .label_value_ff, .label_on_ff, .trig_match_ff, .sym_hit_ff);

    // Free-running sampling clock
    initial
    begin
        forever #20 clk_sys = ~clk_sys;
    end
    // Strobe counters; a doubled pulse shows up as a wrong count
    always @(posedge clk_sys)
    begin
        if (sample_valid_ff === 1'b1)
            n_valid <= n_valid + 1;
        if (slave_strobe_ff === 1'b1)
            n_slave <= n_slave + 1;
    end

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // Expected packing: lowest mask bit first, no gaps, only assigned bits inverted
    function automatic logic [31:0] pack(input logic [63:0] m, input logic [63:0] d,
        input logic neg);
        int k;
        pack = 32'h0;
        k = 0;
        for (int i = 0; i < 64; i++)
            if (m[i])
            begin
                pack[k] = d[i] ^ neg;
                k++;
            end
    endfunction
    task automatic fire(input int pin, input logic [63:0] d, input int exp_n);
        int n0;
        n0 = n_valid;
        tgt.strobe(pin, d);
        chk("strobe count", n_valid - n0, exp_n);
    endtask
    task automatic map(input logic [6:0] idx, input logic [63:0] m, input logic err);
        map_wr = 1'b1;
        map_idx = idx;
        map_mask = m;
        cyc(1);
        chk("map error", map_err_ff, err);
        map_wr = 1'b0;
        cyc(1);
    endtask
    task automatic attr(input logic [6:0] idx, input logic on, input logic neg);
        attr_wr = 1'b1;
        attr_idx = idx;
        attr_on = on;
        attr_neg = neg;
        cyc(1);
        attr_wr = 1'b0;
        cyc(1);
    endtask
    task automatic view(input logic [6:0] idx, input logic on, input logic [31:0] v);
        view_idx = idx;
        cyc(2);
        chk("label on", label_on_ff, on);
        if (on)
            chk("label value", label_value_ff, v);
    endtask
    task automatic trig(input logic [31:0] p, input logic e);
        trig_pattern = p;
        cyc(2);
        chk("trigger match", trig_match_ff, e);
    endtask
    task automatic sym(input logic [9:0] idx, input logic [6:0] lbl, input logic typ,
        input logic [31:0] a, input logic [31:0] b);
        sym_wr = 1'b1;
        sym_wr_idx = idx;
        sym_wr_label = lbl;
        sym_wr_type = typ;
        sym_wr_start = a;
        sym_wr_stop = b;
        cyc(1);
        sym_wr = 1'b0;
        cyc(1);
    endtask
    task automatic query(input logic [9:0] idx, input logic e);
        sym_query_idx = idx;
        cyc(2);
        chk("symbol hit", sym_hit_ff, e);
    endtask

    // Main sequence
    initial
    begin
        int n0;
        logic [31:0] v;
        repeat (20) @(posedge clk_sys);
        #2;
        arst_n = 1'b1;
        cyc(1);
        chk("sample valid", sample_valid_ff, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            mst_edge_en = 12'h001 << i;
            fire(i, 64'hfedc_ba98_7654_3210 + i, 1);
            chk("sample data", sample_data_ff, 64'hfedc_ba98_7654_3210 + i);
        end
        mst_edge_en = 12'h800;
        fire(5, 64'h0, 1);
        mst_edge_en = 12'h009;
        fire(3, 64'h1, 1);
        $display("test clocks done");
        mst_qual_en = 4'hf;
        mst_qual_lvl = 4'h7;
        for (int i = 0; i < 8; i++)
        begin
            mst_edge_en = qtab[i][6] ? 12'h008 : 12'h001;
            mst_qual_mode = {2{qtab[i][5]}};
            tgt.set_qual(qtab[i][4:1]);
            fire(qtab[i][6] ? 3 : 0, 64'h0 + i, qtab[i][0]);
        end
        $display("test qualifiers done");
        mst_qual_en = 4'h0;
        mst_edge_en = 12'h001;
        slv_edge_en = 12'h002;
        pod_mode = 8'h24;
        n0 = n_slave;
        fire(1, 64'h1111_2222_3333_4444, 0);
        fire(1, 64'ha5a5_c3c3_0f0f_9696, 0);
        chk("slave strobes", n_slave - n0, 2);
        fire(0, 64'h1234_5678_9abc_def0, 1);
        s = 64'hc3c3_5678_0f0f_def0;
        chk("sample data", sample_data_ff, s);
        $display("test slave and demux done");
        map(7'h05, m1, 1'b0);
        view(7'h05, 1'b0, 32'h0);
        attr(7'h05, 1'b1, 1'b0);
        view(7'h05, 1'b1, pack(m1, s, 1'b0));
        attr(7'h05, 1'b1, 1'b1);
        view(7'h05, 1'b1, pack(m1, s, 1'b1));
        trig(pack(m1, s, 1'b1), 1'b1);
        trig(pack(m1, s, 1'b0), 1'b0);
        attr(7'h05, 1'b0, 1'b1);
        view(7'h05, 1'b0, 32'h0);
        attr(7'h05, 1'b1, 1'b1);
        view(7'h05, 1'b1, pack(m1, s, 1'b1));
        map(7'h05, 64'h0000_0001_ffff_ffff, 1'b1);
        view(7'h05, 1'b1, pack(m1, s, 1'b1));
        map(7'h05, 64'h0, 1'b1);
        map(7'h7e, m1, 1'b1);
        map(7'h7d, 64'hffff_0000_ffff_0000, 1'b0);
        attr(7'h7d, 1'b1, 1'b0);
        view(7'h7d, 1'b1, 32'hc3c3_0f0f);
        $display("test labels done");
        map(7'h06, 64'h0000_0000_0000_000f, 1'b0);
        attr(7'h06, 1'b1, 1'b0);
        v = pack(m1, s, 1'b1);
        sym(10'h000, 7'h05, 1'b0, v, 32'h0);
        sym(10'h001, 7'h06, 1'b0, v, 32'h0);
        sym(10'h002, 7'h06, 1'b0, 32'h0, 32'h0);
        sym(10'h003, 7'h05, 1'b1, v, v);
        sym(10'h004, 7'h05, 1'b1, 32'h0, 32'hffff_ffff);
        sym(10'h005, 7'h05, 1'b1, v + 32'h1, 32'hffff_ffff);
        sym(10'h3e7, 7'h05, 1'b0, v, 32'h0);
        for (int i = 0; i < 6; i++)
            query(10'(i), 1'((6'h1d >> i) & 6'h01));
        query(10'h3e7, 1'b1);
        // Rewriting a slot as invalid must silence it
        sym_wr_valid = 1'b0;
        sym(10'h3e7, 7'h05, 1'b0, v, 32'h0);
        query(10'h3e7, 1'b0);
        $display("test symbols done");
        end_of_test;
    end
    // Watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        $display("unexpected watchdog: expected end within 5000 cycles, seen none");
        end_of_test;
    end
endmodule
